// File: wao_word_add.sv
// Word add datapath step with optional overflow trap, at most one result per issue.
// Assumes register-file read data arrives with the issue on the same clock.
`timescale 1ns/1ps
module wao_word_add
    import wao_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       resetn,
    input  wire logic                       issue_valid,
    input  wire logic [wao_pkg::WAO_IW-1:0] instr_word,
    output logic      [wao_pkg::WAO_RW-1:0] operand_a_field,
    output logic      [wao_pkg::WAO_RW-1:0] operand_b_field,
    input  wire logic [wao_pkg::WAO_XLEN-1:0] operand_a_data,
    input  wire logic [wao_pkg::WAO_XLEN-1:0] operand_b_data,
    output logic                            rf_wr_en,
    output logic      [wao_pkg::WAO_RW-1:0] rf_wr_addr,
    output logic      [wao_pkg::WAO_XLEN-1:0] rf_wr_data,
    output logic                            ovf_exception,
    output logic                            field_violation
);
    import wao_pkg::*;

    // ************************************************************
    // Decode
    // ************************************************************
    // Read ports are combinational selects so data returns in the issue cycle
    assign operand_a_field = instr_word[WAO_A_HI:WAO_A_LO];
    assign operand_b_field = instr_word[WAO_B_HI:WAO_B_LO];

    function automatic logic is_fn(input logic [WAO_IW-1:0] iw, input logic [5:0] fn);
        is_fn = (iw[WAO_OPC_HI:WAO_OPC_LO] == WAO_OPC_SPEC) && (iw[WAO_FN_HI:WAO_FN_LO] == fn);
    endfunction

    logic                is_trap;
    logic                is_notrap;
    logic [WAO_XLEN:0]   ext_sum;
    logic                ovf;
    logic                sh_bad;

    always_comb begin
        is_trap   = issue_valid && is_fn(instr_word, WAO_FN_TRAP);
        is_notrap = issue_valid && is_fn(instr_word, WAO_FN_NOTRAP);
        ext_sum   = {operand_a_data[WAO_XLEN-1], operand_a_data}
                  + {operand_b_data[WAO_XLEN-1], operand_b_data};
        ovf       = ext_sum[WAO_XLEN] != ext_sum[WAO_XLEN-1];
        // Nonzero shift field: result still produced, only flagged, since any outcome is allowed
        sh_bad    = (is_trap || is_notrap)
                  && (instr_word[WAO_SH_HI:WAO_SH_LO] != WAO_SH_ZERO);
    end

    // ************************************************************
    // Result state
    // ************************************************************
    wao_state_t            state_ff, nxt_state;
    logic                  rf_wr_en_ff, nxt_rf_wr_en;
    logic [WAO_RW-1:0]     rf_wr_addr_ff, nxt_rf_wr_addr;
    logic [WAO_XLEN-1:0]   rf_wr_data_ff, nxt_rf_wr_data;
    logic                  ovf_ff, nxt_ovf;
    logic                  fv_ff, nxt_fv;

    always_comb begin
        nxt_state      = WAO_IDLE;
        nxt_rf_wr_en   = 1'b0;
        nxt_rf_wr_addr = WAO_REG_ZERO;
        nxt_rf_wr_data = WAO_WORD_ZERO;
        nxt_ovf        = 1'b0;
        nxt_fv         = sh_bad;
        if (is_trap && ovf) begin
            nxt_state = WAO_TRAP;
            nxt_ovf   = 1'b1;
        end else if (is_trap || is_notrap) begin
            nxt_state      = WAO_WRITE;
            nxt_rf_wr_en   = 1'b1;
            nxt_rf_wr_addr = instr_word[WAO_D_HI:WAO_D_LO];
            nxt_rf_wr_data = ext_sum[WAO_XLEN-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff      <= WAO_IDLE;
            rf_wr_en_ff   <= 1'b0;
            rf_wr_addr_ff <= WAO_REG_ZERO;
            rf_wr_data_ff <= WAO_WORD_ZERO;
            ovf_ff        <= 1'b0;
            fv_ff         <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            rf_wr_en_ff   <= nxt_rf_wr_en;
            rf_wr_addr_ff <= nxt_rf_wr_addr;
            rf_wr_data_ff <= nxt_rf_wr_data;
            ovf_ff        <= nxt_ovf;
            fv_ff         <= nxt_fv;
        end
    end

    assign rf_wr_en        = rf_wr_en_ff;
    assign rf_wr_addr      = rf_wr_addr_ff;
    assign rf_wr_data      = rf_wr_data_ff;
    assign ovf_exception   = ovf_ff;
    assign field_violation = fv_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    logic [WAO_XLEN-1:0] ref_sum;
    assign ref_sum = operand_a_data + operand_b_data;

    property p_sum;
        @(posedge clk_sys) disable iff (!resetn)
        (is_trap || is_notrap) && !(is_trap && ovf) |=> rf_wr_data == $past(ref_sum);
    endproperty
    a_sum: assert property (p_sum) else $error("sum mismatch");

    property p_trap_nowrite;
        @(posedge clk_sys) disable iff (!resetn)
        is_trap && (operand_a_data[WAO_XLEN-1] == operand_b_data[WAO_XLEN-1])
            && (ref_sum[WAO_XLEN-1] != operand_a_data[WAO_XLEN-1])
            |=> ovf_exception && !rf_wr_en;
    endproperty
    a_trap_nowrite: assert property (p_trap_nowrite) else $error("overflow not trapped");

    property p_write;
        @(posedge clk_sys) disable iff (!resetn)
        is_trap && !ovf |=> rf_wr_en && !ovf_exception
            && rf_wr_addr == $past(instr_word[WAO_D_HI:WAO_D_LO]);
    endproperty
    a_write: assert property (p_write) else $error("missing result write");

    property p_shift;
        @(posedge clk_sys) disable iff (!resetn)
        issue_valid && instr_word[WAO_SH_HI:WAO_SH_LO] != WAO_SH_ZERO
            && (is_trap || is_notrap) |=> field_violation;
    endproperty
    a_shift: assert property (p_shift) else $error("shift field not flagged");

    property p_notrap;
        @(posedge clk_sys) disable iff (!resetn)
        is_notrap |=> rf_wr_en && !ovf_exception;
    endproperty
    a_notrap: assert property (p_notrap) else $error("non-trapping add trapped");

    property p_excl;
        @(posedge clk_sys) disable iff (!resetn)
        !(rf_wr_en && ovf_exception);
    endproperty
    a_excl: assert property (p_excl) else $error("write and trap together");

    property p_ovf_sign;
        @(posedge clk_sys) disable iff (!resetn)
        ovf_exception |-> $past(operand_a_data[WAO_XLEN-1]) == $past(operand_b_data[WAO_XLEN-1]);
    endproperty
    a_ovf_sign: assert property (p_ovf_sign) else $error("trap with unlike signs");

    property p_idle;
        @(posedge clk_sys) disable iff (!resetn)
        !issue_valid |=> !rf_wr_en && !ovf_exception;
    endproperty
    a_idle: assert property (p_idle) else $error("action without issue");

    // Unlike signs can never overflow, so these must always write
    property p_no_false_trap;
        @(posedge clk_sys) disable iff (!resetn)
        is_trap && (operand_a_data[WAO_XLEN-1] != operand_b_data[WAO_XLEN-1])
            |=> rf_wr_en && !ovf_exception;
    endproperty
    a_no_false_trap: assert property (p_no_false_trap) else $error("false trap");

    property p_keep_sign;
        @(posedge clk_sys) disable iff (!resetn)
        is_trap && (ref_sum[WAO_XLEN-1] == operand_a_data[WAO_XLEN-1])
            |=> rf_wr_en && !ovf_exception;
    endproperty
    a_keep_sign: assert property (p_keep_sign) else $error("trap without sign flip");

    property p_refused;
        @(posedge clk_sys) disable iff (!resetn)
        issue_valid && (instr_word[WAO_OPC_HI:WAO_OPC_LO] != WAO_OPC_SPEC
            || (instr_word[WAO_FN_HI:WAO_FN_LO] != WAO_FN_TRAP
                && instr_word[WAO_FN_HI:WAO_FN_LO] != WAO_FN_NOTRAP))
            |=> !rf_wr_en && !ovf_exception && !field_violation;
    endproperty
    a_refused: assert property (p_refused) else $error("action on foreign code");

    property p_nt_addr;
        @(posedge clk_sys) disable iff (!resetn)
        is_notrap |=> rf_wr_addr == $past(instr_word[WAO_D_HI:WAO_D_LO]);
    endproperty
    a_nt_addr: assert property (p_nt_addr) else $error("wrong result register");

    property p_quiet_data;
        @(posedge clk_sys) disable iff (!resetn)
        !rf_wr_en |-> rf_wr_data == WAO_WORD_ZERO;
    endproperty
    a_quiet_data: assert property (p_quiet_data) else $error("data without write");

    property p_fv_cause;
        @(posedge clk_sys) disable iff (!resetn)
        field_violation |-> $past(issue_valid)
            && $past(instr_word[WAO_SH_HI:WAO_SH_LO]) != WAO_SH_ZERO;
    endproperty
    a_fv_cause: assert property (p_fv_cause) else $error("spurious field flag");

    property p_cause;
        @(posedge clk_sys) disable iff (!resetn)
        rf_wr_en || ovf_exception |-> $past(issue_valid);
    endproperty
    a_cause: assert property (p_cause) else $error("answer without issue");

    // One-hot state mirrors the outputs; a stray code would mean a lost answer
    property p_state;
        @(posedge clk_sys) disable iff (!resetn)
        $onehot(state_ff) && ((state_ff == WAO_WRITE) == rf_wr_en)
            && ((state_ff == WAO_TRAP) == ovf_exception);
    endproperty
    a_state: assert property (p_state) else $error("state and outputs disagree");

    // ************************************************************
    // Coverage
    // ************************************************************

    c_trap:   cover property (@(posedge clk_sys) disable iff (!resetn) ovf_exception);
    c_write:  cover property (@(posedge clk_sys) disable iff (!resetn) rf_wr_en);
    c_nt_ovf: cover property (@(posedge clk_sys) disable iff (!resetn) is_notrap && ovf);
    c_b2b:    cover property (@(posedge clk_sys) disable iff (!resetn) rf_wr_en ##1 ovf_exception);
endmodule

// File: wao_pkg.sv
// Package for the word add with overflow trap datapath step.
// Assumes a pipeline that supplies decoded instruction words and register reads.
package wao_pkg;
    // ************************************************************
    // Instruction field layout
    // ************************************************************
    localparam int unsigned WAO_XLEN      = 32;
    localparam int unsigned WAO_IW        = 32;
    localparam int unsigned WAO_RW        = 5;
    localparam int unsigned WAO_OPC_HI    = 31;
    localparam int unsigned WAO_OPC_LO    = 26;
    localparam int unsigned WAO_A_HI      = 25;
    localparam int unsigned WAO_A_LO      = 21;
    localparam int unsigned WAO_B_HI      = 20;
    localparam int unsigned WAO_B_LO      = 16;
    localparam int unsigned WAO_D_HI      = 15;
    localparam int unsigned WAO_D_LO      = 11;
    localparam int unsigned WAO_SH_HI     = 10;
    localparam int unsigned WAO_SH_LO     = 6;
    localparam int unsigned WAO_FN_HI     = 5;
    localparam int unsigned WAO_FN_LO     = 0;
    localparam logic [5:0]  WAO_OPC_SPEC  = 6'h00;
    localparam logic [5:0]  WAO_FN_TRAP   = 6'h20;
    localparam logic [5:0]  WAO_FN_NOTRAP = 6'h21;
    localparam logic [4:0]  WAO_SH_ZERO   = 5'h00;
    localparam logic [31:0] WAO_WORD_ZERO = 32'h00000000;
    localparam logic [4:0]  WAO_REG_ZERO  = 5'h00;
    // ************************************************************
    // Operation states
    // ************************************************************
    typedef enum logic [2:0] {
        WAO_IDLE  = 3'h1,
        WAO_WRITE = 3'h2,
        WAO_TRAP  = 3'h4
    } wao_state_t;
endpackage

// File: wao_rf_model.sv
// Register file model for the far side of the word add step.
// Assumes the bench preloads regs and never targets register 0.
`timescale 1ns/1ps
module wao_rf_model
    import wao_pkg::*;
(
    input  wire logic                         clk_sys,
    input  wire logic [wao_pkg::WAO_RW-1:0]   rd_a_addr,
    input  wire logic [wao_pkg::WAO_RW-1:0]   rd_b_addr,
    output logic      [wao_pkg::WAO_XLEN-1:0] rd_a_data,
    output logic      [wao_pkg::WAO_XLEN-1:0] rd_b_data,
    input  wire logic                         wr_en,
    input  wire logic [wao_pkg::WAO_RW-1:0]   wr_addr,
    input  wire logic [wao_pkg::WAO_XLEN-1:0] wr_data
);
    logic [wao_pkg::WAO_XLEN-1:0] regs [32];
    // Same-cycle reads, as the step expects
    assign rd_a_data = regs[rd_a_addr];
    assign rd_b_data = regs[rd_b_addr];
    always @(posedge clk_sys) begin
        if (wr_en) begin
            regs[wr_addr] <= wr_data;
        end
    end
endmodule

// File: testbench.sv
// Self-checking bench: corner and random adds through a register file model.
// Assumes a one-cycle answer; an idle cycle between issues keeps reads settled.
`timescale 1ns/1ps
module testbench;
    import wao_pkg::*;
    logic        clk_sys, resetn, issue_valid, wr_en, ovf, fviol;
    logic [31:0] instr_word, a_dat, b_dat, wr_data;
    logic [4:0]  a_fld, b_fld, wr_addr;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          seed = 71568;
    wao_word_add i_wao_word_add (.clk_sys(clk_sys), .resetn(resetn),
        .issue_valid(issue_valid), .instr_word(instr_word), .operand_a_field(a_fld),
        .operand_b_field(b_fld), .operand_a_data(a_dat), .operand_b_data(b_dat),
        .rf_wr_en(wr_en), .rf_wr_addr(wr_addr), .rf_wr_data(wr_data),
        .ovf_exception(ovf), .field_violation(fviol));
    wao_rf_model i_wao_rf_model (.clk_sys(clk_sys), .rd_a_addr(a_fld), .rd_b_addr(b_fld),
        .rd_a_data(a_dat), .rd_b_data(b_dat), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic ovf_of(input logic [31:0] x, input logic [31:0] y);
        logic [32:0] t;
        t = {x[31], x} + {y[31], y};
        return t[32] != t[31];
    endfunction
    // ************************************************************
    // One issue, its answer, then the idle cycle after it
    // ************************************************************
    task automatic op(input logic [5:0] fn, input logic [4:0] ra, rb, rd, sh);
        logic [31:0] x, y, old;
        logic        add, trap;
        x = i_wao_rf_model.regs[ra];
        y = i_wao_rf_model.regs[rb];
        old = i_wao_rf_model.regs[rd];
        add = (fn === WAO_FN_TRAP) || (fn === WAO_FN_NOTRAP);
        trap = (fn === WAO_FN_TRAP) && ovf_of(x, y);
        @(posedge clk_sys);
        issue_valid <= 1'b1;
        instr_word <= {WAO_OPC_SPEC, ra, rb, rd, sh, fn};
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        #1;
        chk(wr_en, add && !trap);
        chk(ovf, trap);
        chk(fviol, add && sh != 5'h00);
        if (add && !trap) begin
            chk(wr_addr, rd);
            chk(wr_data, x + y);
        end else begin
            chk(wr_data, WAO_WORD_ZERO);
        end
        @(posedge clk_sys);
        #1;
        chk({wr_en, ovf, fviol}, 32'h0);
        chk(i_wao_rf_model.regs[rd], (add && !trap) ? x + y : old);
    endtask
    task automatic complete_run;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        resetn = 1'b0;
        issue_valid = 1'b0;
        instr_word = 32'h00000000;
        for (int i = 0; i < 32; i++) i_wao_rf_model.regs[i] = (i == 0) ? 0 : $random(seed);
        i_wao_rf_model.regs[1] = 32'h7FFFFFFF;
        i_wao_rf_model.regs[2] = 32'h00000001;
        i_wao_rf_model.regs[3] = 32'h80000000;
        i_wao_rf_model.regs[4] = 32'hFFFFFFFF;
        i_wao_rf_model.regs[15] = 32'h0000ABCD;
        repeat (4) @(posedge clk_sys);
        chk({wr_en, ovf, fviol}, 32'h0);
        resetn <= 1'b1;
        op(WAO_FN_TRAP, 5'h01, 5'h02, 5'h05, 5'h00);
        op(WAO_FN_NOTRAP, 5'h01, 5'h02, 5'h06, 5'h00);
        op(WAO_FN_TRAP, 5'h03, 5'h04, 5'h07, 5'h00);
        op(WAO_FN_TRAP, 5'h01, 5'h04, 5'h08, 5'h00);
        op(WAO_FN_NOTRAP, 5'h03, 5'h03, 5'h09, 5'h00);
        op(WAO_FN_TRAP, 5'h02, 5'h02, 5'h0A, 5'h10);
        op(6'h22, 5'h01, 5'h02, 5'h0B, 5'h00);
        // Back to back issues, a foreign opcode, then reset cutting a standing write
        @(posedge clk_sys);
        issue_valid <= 1'b1;
        instr_word  <= {WAO_OPC_SPEC, 5'h02, 5'h02, 5'h0C, WAO_SH_ZERO, WAO_FN_NOTRAP};
        @(posedge clk_sys);
        instr_word  <= {WAO_OPC_SPEC, 5'h01, 5'h02, 5'h0D, WAO_SH_ZERO, WAO_FN_TRAP};
        #1;
        chk({wr_en, ovf, wr_addr}, {2'h2, 5'h0C});
        chk(wr_data, 32'h00000002);
        @(posedge clk_sys);
        instr_word  <= {6'h01, 5'h01, 5'h02, 5'h0E, WAO_SH_ZERO, WAO_FN_TRAP};
        #1;
        chk({wr_en, ovf}, 2'h1);
        chk(wr_data, WAO_WORD_ZERO);
        @(posedge clk_sys);
        instr_word  <= {WAO_OPC_SPEC, 5'h02, 5'h02, 5'h0F, WAO_SH_ZERO, WAO_FN_NOTRAP};
        #1;
        chk({wr_en, ovf, fviol}, 32'h0);
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        #1;
        chk(wr_en, 1'b1);
        resetn <= 1'b0;
        #1;
        chk({wr_en, ovf, fviol}, 32'h0);
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        chk(i_wao_rf_model.regs[12], 32'h00000002);
        chk(i_wao_rf_model.regs[15], 32'h0000ABCD);
        for (int i = 0; i < 300; i++) begin
            op($random(seed) & 1 ? WAO_FN_TRAP : WAO_FN_NOTRAP, 5'($random(seed)),
               5'($random(seed)), 5'({$random(seed)} % 31 + 1), 5'h00);
        end
        complete_run();
    end
endmodule
